// >>> fss_device.sv
// Fail-safe status and control register bank, device end of the safety link
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module fss_device
  import fss_pkg::*;
#(
  parameter int RST_PULSE_CYCLES = RST_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  fss_link_if.dev lnk,
  input wire logic [15:0] ovuv_events,
  input wire logic [15:0] ios_events,
  input wire logic [15:0] diag_events,
  input wire logic pg_pad_level,
  input wire logic reset_pad_level,
  input wire logic safe_out_pad_level,
  input wire logic fault_in1_level,
  input wire logic fault_in2_level,
  input wire logic err_monitor_level,
  input wire logic analog_test1_pass,
  input wire logic analog_test2_pass,
  input wire logic logic_test_pass,
  input wire logic [15:0] release_expected,
  output logic safe_state_output,
  output logic reset_output_pin,
  output logic return_to_init_pulse,
  output logic err_monitor_ack_pulse,
  output logic irq_out
);
  localparam int CW = $clog2(RST_PULSE_CYCLES + 1);

  logic ack_q;
  logic err_q;
  logic [15:0] rdata_q;
  logic [15:0] ovuv_q;
  logic [15:0] ios_q;
  logic [15:0] diag_q;
  logic [15:0] mask_q;
  logic safe_q;
  logic rst_pin_q;
  logic [CW-1:0] rst_cnt_q;
  logic init_q;
  logic eack_q;
  logic irq_q;
  logic take;
  logic bad_addr;
  logic [15:0] wr_ovuv;
  logic [15:0] wr_ios;
  logic [15:0] wr_diag;
  logic [15:0] ios_live;
  logic [15:0] diag_live;
  logic [15:0] rd_mux;
  logic [15:0] ios_set;
  logic [15:0] diag_set;
  logic [9:0] irq_src;

  // ********************************************************
  // Link decode
  // ********************************************************
  assign take = lnk.req && !ack_q;
  assign bad_addr = lnk.addr > REG_MASK;
  assign wr_ovuv = (take && lnk.wr && lnk.addr == REG_OVUV) ? lnk.wdata : 16'h0000;
  assign wr_ios = (take && lnk.wr && lnk.addr == REG_IOS) ? lnk.wdata : 16'h0000;
  assign wr_diag = (take && lnk.wr && lnk.addr == REG_DIAG) ? lnk.wdata : 16'h0000;

  always_comb begin
    ios_live = 16'h0000;
    ios_live[PG_PAD_LEVEL] = pg_pad_level; // [R7]
    ios_live[RESET_DRIVER_CMD] = !rst_pin_q; // [R7]
    ios_live[RESET_PAD_LEVEL] = reset_pad_level; // [R7]
    ios_live[SAFE_OUT_DRIVER_CMD] = !safe_q; // [R10]
    ios_live[SAFE_OUT_PAD_LEVEL] = safe_out_pad_level; // [R10]
    ios_live[FAULT_IN2_LEVEL] = fault_in2_level; // [R14]
    ios_live[FAULT_IN1_LEVEL] = fault_in1_level; // [R14]
    diag_live = 16'h0000;
    diag_live[ERR_MONITOR_LEVEL] = err_monitor_level; // [R16]
    diag_live[ANALOG_TEST1_PASS] = analog_test1_pass; // [R18]
    diag_live[ANALOG_TEST2_PASS] = analog_test2_pass; // [R18]
    diag_live[LOGIC_TEST_PASS] = logic_test_pass; // [R18]
  end

  // Write-only and reserved bits read as zero
  always_comb begin
    unique case (lnk.addr)
      REG_OVUV: rd_mux = ovuv_q & OVUV_W1C; // [R23]
      REG_IOS: rd_mux = (ios_q & IOS_W1C) | ios_live; // [R23]
      REG_DIAG: rd_mux = (diag_q & DIAG_W1C) | diag_live; // [R23]
      REG_MASK: rd_mux = mask_q & MASK_RW; // [R23]
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (take) begin
      ack_q <= 1'b1;
      err_q <= bad_addr;
      rdata_q <= lnk.wr ? 16'h0000 : rd_mux;
    end else begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  assign lnk.ack = ack_q;
  assign lnk.err = err_q;
  assign lnk.rdata = rdata_q;

  // ********************************************************
  // Latched flags: set wins over write-one-to-clear
  // ********************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ovuv_q <= OVUV_RST; // [R1] [R2]
    end else begin
      ovuv_q <= ((ovuv_q & ~wr_ovuv) | ovuv_events) & OVUV_W1C; // [R1] [R2] [R23]
    end
  end

  always_comb begin
    ios_set = ios_events;
    ios_set[RESET_EVENT_FLAG] = ios_events[RESET_EVENT_FLAG] || (rst_pin_q && rst_cnt_q == '0); // [R8]
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ios_q <= IOS_RST; // [R4] [R5] [R6] [R8] [R11]
    end else begin
      ios_q <= ((ios_q & ~wr_ios) | ios_set) & IOS_W1C; // [R4] [R5] [R6] [R8] [R11] [R23]
    end
  end

  always_comb begin
    diag_set = diag_events;
    diag_set[SERIAL_ACCESS_VIOLATION] = diag_events[SERIAL_ACCESS_VIOLATION] || (take && bad_addr); // [R20]
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      diag_q <= DIAG_RST;
    end else begin
      diag_q <= ((diag_q & ~wr_diag) | diag_set) & DIAG_W1C; // [R15] [R16] [R17] [R19] [R20] [R21] [R23]
    end
  end

  // ********************************************************
  // Interrupt inhibit and interrupt output
  // ********************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_q <= MASK_RST; // [R22]
    end else if (take && lnk.wr && lnk.addr == REG_MASK) begin
      mask_q <= lnk.wdata & MASK_RW; // [R22]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_irq
      assign irq_src[gi] = |(ovuv_q & IRQ_OVUV_SRC[gi]) || |(diag_q & IRQ_DIAG_SRC[gi]);
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_src & ~mask_q[9:0]); // [R22]
    end
  end

  // ********************************************************
  // Safe state output and release word
  // ********************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      safe_q <= 1'b1;
    end else if (wr_ios[SAFE_OUT_REQUEST]) begin
      safe_q <= 1'b1; // [R12]
    end else if (take && lnk.wr && lnk.addr == REG_RELEASE && lnk.wdata == release_expected) begin
      safe_q <= 1'b0; // [R3]
    end
  end

  // ********************************************************
  // Reset output pulse
  // ********************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_pin_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (wr_ios[RESET_PULSE_REQUEST]) begin
      rst_pin_q <= 1'b1; // [R9]
      rst_cnt_q <= CW'(RST_PULSE_CYCLES - 1);
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end else begin
      rst_pin_q <= 1'b0;
    end
  end

  // ********************************************************
  // One-cycle request pulses
  // ********************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      init_q <= 1'b0;
      eack_q <= 1'b0;
    end else begin
      init_q <= wr_ios[RETURN_TO_INIT_REQUEST]; // [R13]
      eack_q <= wr_diag[ERR_MONITOR_ACK]; // [R16]
    end
  end

  assign safe_state_output = safe_q;
  assign reset_output_pin = rst_pin_q;
  assign return_to_init_pulse = init_q;
  assign err_monitor_ack_pulse = eack_q;
  assign irq_out = irq_q;
endmodule // fss_device

// >>> fss_pkg.sv
// Shared constants for the fail-safe status register bank and its host controller
// How it works
// R1: Monitor-1 over/under flags latch, write-one clears.
// R2: Reference overvoltage and oscillator drift latch, W1C.
// R3: Release word compared before freeing safe output.
// R4: Power-good short-high flag latches, write-one clears.
// R5: Power-good event flag latches, write-one clears.
// R6: External reset flag latches, write-one clears.
// R7: Power-good pad, reset driver, reset pad live.
// R8: Reset event and reset short flags, W1C.
// R9: Writing one requests a reset output pulse.
// R10: Safe output driver and pad level read live.
// R11: Safe output short-high flag latches, W1C.
// R12: Writing one asserts the safe state output.
// R13: Writing one returns safety machine to init.
// R14: Both fault input levels read live.
// R15: Pair, first, second fault error flags, W1C.
// R16: Error monitor flag, live level, acknowledge bit.
// R17: Watchdog bad data and bad timing flags, W1C.
// R18: Analog and logic self-test pass bits read-only.
// R19: Serial clock count error flag, write-one clears.
// R20: Serial and two-wire access violation flags, W1C.
// R21: Serial and two-wire CRC error flags, W1C.
// R22: Per-source interrupt inhibit bits, cleared at reset.
// R23: Zero writes keep flags; reserved bits read zero.
package fss_pkg;
  localparam int DW = 16;
  localparam int AW = 3;
  // Register indices on the safety link
  localparam logic [2:0] REG_OVUV = 3'h0;
  localparam logic [2:0] REG_RELEASE = 3'h1;
  localparam logic [2:0] REG_IOS = 3'h2;
  localparam logic [2:0] REG_DIAG = 3'h3;
  localparam logic [2:0] REG_MASK = 3'h4;
  // Field layouts (bit n of a register is index n)
  localparam logic [15:0] OVUV_W1C = 16'hFFF6;
  localparam logic [15:0] OVUV_RST = 16'h5550;
  localparam logic [15:0] IOS_W1C = 16'hD310;
  localparam logic [15:0] IOS_RST = 16'h4200;
  localparam logic [15:0] DIAG_W1C = 16'hEB3E;
  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [15:0] MASK_RW = 16'h03FF;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam int MON1_OVER_FLAG = 5;
  localparam int MON1_UNDER_FLAG = 4;
  localparam int PG_PAD_LEVEL = 13;
  localparam int RESET_DRIVER_CMD = 11;
  localparam int RESET_PAD_LEVEL = 10;
  localparam int RESET_EVENT_FLAG = 9;
  localparam int RESET_PULSE_REQUEST = 7;
  localparam int SAFE_OUT_DRIVER_CMD = 6;
  localparam int SAFE_OUT_PAD_LEVEL = 5;
  localparam int SAFE_OUT_REQUEST = 3;
  localparam int RETURN_TO_INIT_REQUEST = 2;
  localparam int FAULT_IN2_LEVEL = 1;
  localparam int FAULT_IN1_LEVEL = 0;
  localparam int FAULT_PAIR_ERROR_FLAG = 15;
  localparam int FAULT_IN1_ERROR_FLAG = 14;
  localparam int FAULT_IN2_ERROR_FLAG = 13;
  localparam int ERR_MONITOR_ACK = 12;
  localparam int ERR_MONITOR_FLAG = 11;
  localparam int ERR_MONITOR_LEVEL = 10;
  localparam int WDOG_BAD_DATA_FLAG = 9;
  localparam int WDOG_BAD_TIMING_FLAG = 8;
  localparam int ANALOG_TEST1_PASS = 7;
  localparam int ANALOG_TEST2_PASS = 6;
  localparam int SERIAL_ACCESS_VIOLATION = 4;
  localparam int LOGIC_TEST_PASS = 0;
  // Interrupt inhibit bit to source flags
  localparam logic [15:0] IRQ_OVUV_SRC [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hC000,
                                               16'h3000, 16'h0030, 16'h00C0, 16'h0300, 16'h0C00};
  localparam logic [15:0] IRQ_DIAG_SRC [10] = '{16'h4000, 16'h2000, 16'h0800, 16'h0300, 16'h0000,
                                               16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // Timing
  localparam int CLK_MHZ = 40;
  localparam int RST_PULSE_US = 10000;
  localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
  // Host register map (byte addresses)
  localparam logic [3:0] AV_CMD = 4'h0;
  localparam logic [3:0] AV_STAT = 4'h4;
  localparam logic [3:0] AV_RDATA = 4'h8;
  localparam int CMD_WR_BIT = 31;
  localparam int CMD_ADDR_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  typedef enum logic [0:0] {HS_IDLE = 1'b0, HS_WAIT = 1'b1} fss_host_e;
endpackage

// >>> fss_link_if.sv
// Register access link between the safety register bank and its host controller
`timescale 1ns/1ps
interface fss_link_if;
  logic req;
  logic wr;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic err;
  modport dev (input req, input wr, input addr, input wdata, output rdata, output ack, output err);
  modport host (output req, output wr, output addr, output wdata, input rdata, input ack, input err);
endinterface

// >>> fss_host.sv
// Host controller end: Avalon-MM command registers driving the safety link
`timescale 1ns/1ps
module fss_host
  import fss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  fss_link_if.host lnk
);
  fss_host_e state_q;
  logic wait_q;
  logic [31:0] rdout_q;
  logic req_q;
  logic wr_q;
  logic [2:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic err_q;
  logic go;
  logic [31:0] rd_mux;

  // ********************************************************
  // Avalon slave: one wait cycle per access
  // ********************************************************
  assign go = !wait_q && avs_write && avs_address == AV_CMD && state_q == HS_IDLE;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == AV_STAT) begin
      rd_mux[STAT_BUSY_BIT] = state_q == HS_WAIT;
      rd_mux[STAT_ERR_BIT] = err_q;
    end else if (avs_address == AV_RDATA) begin
      rd_mux[15:0] = rdata_q;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdout_q <= 32'h0000_0000;
    end else if (wait_q) begin
      if (avs_read || avs_write) begin
        wait_q <= 1'b0;
        rdout_q <= avs_read ? rd_mux : 32'h0000_0000;
      end
    end else begin
      wait_q <= 1'b1;
    end
  end

  // ********************************************************
  // Link sequencer
  // ********************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= HS_IDLE;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      err_q <= 1'b0;
    end else begin
      unique case (state_q)
        HS_IDLE: begin
          if (go) begin
            req_q <= 1'b1;
            wr_q <= avs_writedata[CMD_WR_BIT]; // [R3] [R9] [R12] [R13] [R16]
            addr_q <= avs_writedata[CMD_ADDR_LSB +: AW];
            wdata_q <= avs_writedata[DW-1:0];
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (lnk.ack) begin
            req_q <= 1'b0;
            rdata_q <= lnk.rdata;
            err_q <= lnk.err;
            state_q <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdout_q;
  assign lnk.req = req_q;
  assign lnk.wr = wr_q;
  assign lnk.addr = addr_q;
  assign lnk.wdata = wdata_q;
endmodule // fss_host

// >>> fss_checker.sv
// Link protocol checker for the register bank and its host controller
`timescale 1ns/1ps
module fss_checker
  import fss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic wr,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic err
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire rd_ack = ack && !wr;
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_done;
    ack ##1 (!ack && !req);
  endsequence
  AST_ANSWER: assert property (s_take |=> s_done)
    else $error("link answer late");
  AST_ACK_CAUSE: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  AST_ERR_ACK: assert property (err |-> ack)
    else $error("err outside ack");
  AST_ERR_RANGE: assert property (ack |-> (err == (addr > 3'h4)))
    else $error("err wrong for index");
  AST_HOLD: assert property (s_take |=> $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request moved before ack");
  AST_REL_ZERO: assert property (rd_ack && addr == REG_RELEASE |-> rdata == 16'h0000)
    else $error("release word readable");
  AST_MASK_RSVD: assert property (rd_ack && addr == REG_MASK |-> (rdata & ~MASK_RW) == 16'h0000)
    else $error("mask reserved bits set");
  AST_IOS_RSVD: assert property (rd_ack && addr == REG_IOS |-> (rdata & 16'h008C) == 16'h0000)
    else $error("request bits readable");
endmodule // fss_checker

// >>> test_failsafe_safety_status_regs.sv
// Self-checking bench for the safety register bank and its host controller
`timescale 1ns/1ps
module test_failsafe_safety_status_regs;
  import fss_pkg::*;
  localparam int PULSE = 8;
  localparam logic [15:0] REL = 16'hA5C3;
  localparam logic [2:0] IDX [3] = '{REG_OVUV, REG_IOS, REG_DIAG};
  localparam logic [15:0] W1C [3] = '{OVUV_W1C, IOS_W1C, DIAG_W1C};
  localparam logic [15:0] RSTV [3] = '{OVUV_RST, IOS_RST, DIAG_RST};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, w32;
  logic avs_waitrequest, safe_state_output, reset_output_pin, ret_pulse, ack_pulse, irq_out, e;
  logic [15:0] ev [3] = '{default: 16'h0000};
  logic [8:0] lvl = 9'h15D;
  logic [15:0] q;
  int failures = 0;
  int check_count = 0;
  int rst_hi = 0;
  int ret_n = 0;
  int ack_n = 0;
  always #12.5 sys_clk = ~sys_clk;
  fss_link_if u_fss_link_if();
  fss_device #(.RST_PULSE_CYCLES(PULSE)) u_fss_device (.sys_clk(sys_clk), .reset(reset), .lnk(u_fss_link_if),
    .ovuv_events(ev[0]), .ios_events(ev[1]), .diag_events(ev[2]), .pg_pad_level(lvl[8]),
    .reset_pad_level(lvl[7]), .safe_out_pad_level(lvl[6]), .fault_in1_level(lvl[5]), .fault_in2_level(lvl[4]),
    .err_monitor_level(lvl[3]), .analog_test1_pass(lvl[2]), .analog_test2_pass(lvl[1]), .logic_test_pass(lvl[0]),
    .release_expected(REL), .safe_state_output(safe_state_output), .reset_output_pin(reset_output_pin),
    .return_to_init_pulse(ret_pulse), .err_monitor_ack_pulse(ack_pulse), .irq_out(irq_out));
  fss_host u_fss_host (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(u_fss_link_if));
  fss_checker u_fss_checker (.sys_clk(sys_clk), .reset(reset), .req(u_fss_link_if.req), .wr(u_fss_link_if.wr),
    .addr(u_fss_link_if.addr), .wdata(u_fss_link_if.wdata), .rdata(u_fss_link_if.rdata),
    .ack(u_fss_link_if.ack), .err(u_fss_link_if.err));
  always @(posedge sys_clk) begin
    if (reset_output_pin === 1'b1) rst_hi++;
    if (ret_pulse === 1'b1) ret_n++;
    if (ack_pulse === 1'b1) ack_n++;
  end
  // ****
  // Tasks
  // ****
  function automatic logic [15:0] live(int r);
    if (r == 1) return {2'h0, lvl[8], 1'h0, 1'h1, lvl[7], 4'h0, lvl[6], 3'h0, lvl[4], lvl[5]};
    if (r == 2) return {5'h00, lvl[3], 2'h0, lvl[2], lvl[1], 5'h00, lvl[0]};
    return 16'h0000;
  endfunction
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp, input string m);
    chk({15'h0000, got}, {15'h0000, exp}, m);
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      $display("[FAIL] %0t bus timeout", $time);
      failures++;
      finish_test();
    end
  endtask
  task automatic lk(input logic w, input logic [2:0] i, input logic [15:0] d, output logic [15:0] rq, output logic re);
    logic [31:0] r;
    int n;
    av(1'b1, AV_CMD, {w, 12'h000, i, d}, r);
    for (n = 0; n < 20; n++) begin
      av(1'b0, AV_STAT, 32'h0, r);
      if (r[STAT_BUSY_BIT] === 1'b0) break;
    end
    re = r[STAT_ERR_BIT];
    av(1'b0, AV_RDATA, 32'h0, r);
    rq = r[15:0];
    if (n >= 20) begin
      $display("[FAIL] %0t link timeout", $time);
      failures++;
      finish_test();
    end
  endtask
  task automatic rdchk(input logic [2:0] i, input logic [15:0] exp, input string m);
    lk(1'b0, i, 16'h0000, q, e);
    chk(q, exp, m);
  endtask
  task automatic pulse(input int r, input logic [15:0] v);
    @(posedge sys_clk);
    ev[r] <= v;
    @(posedge sys_clk);
    ev[r] <= 16'h0000;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    for (int r = 0; r < 3; r++) rdchk(IDX[r], RSTV[r] | live(r), "reset");
    rdchk(REG_MASK, MASK_RST, "mask reset");
    chkb(irq_out, 1'b1, "irq on flags");
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      lk(1'b1, IDX[r], 16'h0000, q, e);
      rdchk(IDX[r], RSTV[r] | live(r), "zero write");
      pulse(r, 16'hFFFF);
      rdchk(IDX[r], W1C[r] | live(r), "flags set");
      lk(1'b1, IDX[r], W1C[r], q, e);
      rdchk(IDX[r], live(r), "flags clear");
    end
    chkb(irq_out, 1'b0, "irq idle");
    lk(1'b1, REG_MASK, 16'hFFFF, q, e);
    rdchk(REG_MASK, MASK_RW, "mask rw");
    pulse(0, 16'h0030);
    repeat (3) @(posedge sys_clk);
    chkb(irq_out, 1'b0, "masked");
    lk(1'b1, REG_MASK, 16'h0000, q, e);
    chkb(irq_out, 1'b1, "unmasked");
    lk(1'b1, REG_OVUV, 16'h0030, q, e);
    repeat (3) @(posedge sys_clk);
    chkb(irq_out, 1'b0, "irq cleared");
    $display("test flags done");
    lk(1'b0, 3'h5, 16'h0000, q, e);
    chkb(e, 1'b1, "unmapped read");
    lk(1'b1, 3'h7, 16'hFFFF, q, e);
    chkb(e, 1'b1, "unmapped write");
    rdchk(REG_DIAG, live(2) | 16'h0010, "violation");
    lk(1'b1, REG_DIAG, 16'h0010, q, e);
    rdchk(REG_DIAG, live(2), "violation clear");
    av(1'b0, 4'hC, 32'h0, w32);
    chk(w32[15:0], 16'h0000, "host unmapped");
    rdchk(REG_RELEASE, 16'h0000, "release read");
    lk(1'b1, REG_RELEASE, ~REL, q, e);
    chkb(safe_state_output, 1'b1, "bad word");
    lk(1'b1, REG_RELEASE, REL, q, e);
    chkb(safe_state_output, 1'b0, "released");
    rdchk(REG_IOS, live(1) | 16'h0040, "driver live");
    lk(1'b1, REG_IOS, 16'h0000, q, e);
    chkb(safe_state_output, 1'b0, "zero request");
    lk(1'b1, REG_IOS, 16'h0008, q, e);
    chkb(safe_state_output, 1'b1, "safe request");
    $display("test access done");
    lk(1'b1, REG_IOS, 16'h0080, q, e);
    repeat (PULSE + 4) @(posedge sys_clk);
    chk(rst_hi[15:0], 16'(PULSE), "pulse length");
    rdchk(REG_IOS, live(1) | 16'h0200, "reset event");
    lk(1'b1, REG_IOS, 16'h0004, q, e);
    lk(1'b1, REG_DIAG, 16'h1000, q, e);
    chk(ret_n[15:0], 16'h0001, "init pulse");
    chk(ack_n[15:0], 16'h0001, "ack pulse");
    rdchk(REG_DIAG, live(2), "ack reads zero");
    @(posedge sys_clk);
    lvl <= ~lvl;
    @(posedge sys_clk);
    rdchk(REG_IOS, live(1) | 16'h0200, "live ios");
    rdchk(REG_DIAG, live(2), "live diag");
    $display("test pulses done");
    finish_test();
  end
endmodule // test_failsafe_safety_status_regs
